// ### design/lod_regs.sv
// File holds the register bank top module.
// Assumes synchronous inputs and an Avalon-MM master on ref_clk.
`timescale 1ns/100ps
module lod_regs #(
  parameter int unsigned CHANNELS  = lod_pkg::CHANNELS,
  parameter int unsigned PORT_PINS = lod_pkg::PORT_PINS
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  // Avalon-MM slave
  input  wire logic [lod_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [lod_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [lod_pkg::DATA_W-1:0] avs_readdata,
  output logic                           avs_waitrequest,
  output logic      [1:0]                avs_response,
  // Analog comparator outputs and excitation phase
  input  wire logic [7:0]                comp_pos_off,
  input  wire logic [7:0]                comp_neg_off,
  input  wire logic                      ac_phase,
  // Port pins
  input  wire logic [3:0]                port_pin_in,
  output logic      [3:0]                port_pin_out,
  output logic      [3:0]                port_pin_oe,
  // Analog controls and status
  output lod_pkg::lod_ctrl_t             ctrl_out,
  output lod_pkg::lod_route_t            route_out,
  output lod_pkg::lod_stat_t             stat_out
);

  if (CHANNELS != lod_pkg::CHANNELS ||
      PORT_PINS != lod_pkg::PORT_PINS) begin : g_param_check
    $error("lod_regs serves 8 channels and 4 port pins only");
  end

  default clocking cb_check @(posedge ref_clk);
  endclocking

  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  logic       ack_ff;
  logic [7:0] idx;
  logic       wr_go;
  logic       rd_go;
  logic       lane0;

  assign idx   = {2'b00, avs_address[7:2]};
  assign lane0 = avs_byteenable[0];
  assign wr_go = avs_write && ack_ff;
  assign rd_go = avs_read && !ack_ff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read || avs_write) && !ack_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] sense_pos_ff, sense_neg_ff, swap_ff;
  logic [7:0] port_ff, misc_one_ff, conversion_comparator_config_ff, electrode_off_control_reg_ctrl_ff;
  logic [7:0] sel_ff [CHANNELS];
  logic [7:0] stat_pos_ff, stat_neg_ff;
  logic [3:0] pins_ff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sense_pos_ff <= lod_pkg::RST_ZERO;
      sense_neg_ff <= lod_pkg::RST_ZERO;
      swap_ff      <= lod_pkg::RST_ZERO;
      misc_one_ff  <= lod_pkg::RST_ZERO;
      conversion_comparator_config_ff   <= lod_pkg::RST_ZERO;
      electrode_off_control_reg_ctrl_ff <= lod_pkg::RST_ZERO;
    end else if (wr_go && lane0) begin
      unique case (idx)
        lod_pkg::IDX_SENSE_POS: sense_pos_ff <= avs_writedata[7:0];
        lod_pkg::IDX_SENSE_NEG: sense_neg_ff <= avs_writedata[7:0];
        lod_pkg::IDX_DIR_SWAP:  swap_ff <= avs_writedata[7:0];
        lod_pkg::IDX_MISC_ONE:
          misc_one_ff <= avs_writedata[7:0] & lod_pkg::MASK_MISC_ONE;
        lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG:
          conversion_comparator_config_ff <= avs_writedata[7:0] & lod_pkg::MASK_CONVERSION_COMPARATOR_CONFIG;
        lod_pkg::IDX_ELECTRODE_OFF_CONTROL_REG_CTRL: electrode_off_control_reg_ctrl_ff <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Per-channel input select; write data holds channel and code
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CHANNELS; i++)
        sel_ff[i] <= lod_pkg::RST_ZERO;
    end else if (wr_go && lane0 && idx == lod_pkg::IDX_INPUT_SEL) begin
      sel_ff[avs_writedata[lod_pkg::SEL_CH_LSB +: 3]] <=
        {5'b0_0000, avs_writedata[lod_pkg::SEL_CODE_LSB +: 3]};
    end
  end

  // Port: direction writes always, value only on output pins
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      port_ff <= lod_pkg::RST_PORT;
    end else if (wr_go && lane0 && idx == lod_pkg::IDX_PORT) begin
      for (int p = 0; p < PORT_PINS; p++) begin
        port_ff[lod_pkg::PORT_DIR_LSB + p] <=
          avs_writedata[lod_pkg::PORT_DIR_LSB + p];
        if (!port_ff[lod_pkg::PORT_DIR_LSB + p])
          port_ff[lod_pkg::PORT_VAL_LSB + p] <=
            avs_writedata[lod_pkg::PORT_VAL_LSB + p];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      port_pin_out <= 4'h0;
      port_pin_oe  <= 4'h0;
      pins_ff      <= 4'h0;
    end else begin
      port_pin_out <= port_ff[lod_pkg::PORT_VAL_LSB +: 4];
      port_pin_oe  <= ~port_ff[lod_pkg::PORT_DIR_LSB +: 4];
      pins_ff      <= port_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Status capture: comparators only when enabled; no bus write path
  // ----------------------------------------------------------------
  logic comp_en;
  assign comp_en = conversion_comparator_config_ff[lod_pkg::COMP_EN_BIT];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stat_pos_ff <= lod_pkg::RST_ZERO;
      stat_neg_ff <= lod_pkg::RST_ZERO;
    end else if (comp_en) begin
      stat_pos_ff <= comp_pos_off;
      stat_neg_ff <= comp_neg_off;
    end else begin
      stat_pos_ff <= lod_pkg::RST_ZERO;
      stat_neg_ff <= lod_pkg::RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = lod_pkg::RST_ZERO;
    unique case (idx)
      lod_pkg::IDX_SENSE_POS: rd_byte = sense_pos_ff;
      lod_pkg::IDX_SENSE_NEG: rd_byte = sense_neg_ff;
      lod_pkg::IDX_DIR_SWAP:  rd_byte = swap_ff;
      lod_pkg::IDX_STAT_POS:  rd_byte = stat_pos_ff;
      lod_pkg::IDX_STAT_NEG:  rd_byte = stat_neg_ff;
      lod_pkg::IDX_PORT:
        rd_byte = {pins_ff, port_ff[lod_pkg::PORT_DIR_LSB +: 4]};
      lod_pkg::IDX_MISC_ONE:  rd_byte = misc_one_ff;
      lod_pkg::IDX_MISC_TWO:  rd_byte = lod_pkg::MASK_MISC_TWO;
      lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG:   rd_byte = conversion_comparator_config_ff;
      lod_pkg::IDX_ELECTRODE_OFF_CONTROL_REG_CTRL: rd_byte = electrode_off_control_reg_ctrl_ff;
      default:                rd_byte = lod_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      avs_readdata <= lod_pkg::DATA_ZERO;
      avs_response <= 2'b00;
    end else if (rd_go) begin
      avs_readdata <= {24'h00_0000, rd_byte};
      avs_response <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // Analog control, routing and status outputs
  // ----------------------------------------------------------------
  logic [7:0] to_pos, to_neg;
  always_comb begin
    to_pos = 8'h00;
    to_neg = 8'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      to_pos[i] = sel_ff[i][2:0] == lod_pkg::SEL_BIAS_POS;
      to_neg[i] = sel_ff[i][2:0] == lod_pkg::SEL_BIAS_NEG;
    end
  end

  logic       is_ac;
  logic [7:0] up_pos;
  assign is_ac  = electrode_off_control_reg_ctrl_ff[lod_pkg::FREQ_LSB +: 2] != lod_pkg::FREQ_DC;
  // AC mode flips the pull direction each half period
  assign up_pos = is_ac ? {8{ac_phase}} ^ swap_ff : ~swap_ff;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_out  <= '0;
      route_out <= '0;
      stat_out  <= '0;
    end else begin
      ctrl_out.pos_detect_enable <= sense_pos_ff;
      ctrl_out.neg_detect_enable <= sense_neg_ff;
      ctrl_out.excitation_direction_swap <= swap_ff;
      ctrl_out.excitation_current_level <=
        electrode_off_control_reg_ctrl_ff[lod_pkg::CUR_LSB +: 2];
      ctrl_out.comparator_threshold <=
        electrode_off_control_reg_ctrl_ff[lod_pkg::TH_LSB +: 3];
      ctrl_out.excitation_frequency_select <=
        electrode_off_control_reg_ctrl_ff[lod_pkg::FREQ_LSB +: 2];
      ctrl_out.shared_reference_switch <=
        misc_one_ff[lod_pkg::SHREF_BIT];
      ctrl_out.single_shot_mode <= conversion_comparator_config_ff[lod_pkg::SINGLE_BIT];
      ctrl_out.detect_comparator_enable <= comp_en;
      route_out.bias_to_pos <= to_pos;
      route_out.bias_to_neg <= to_neg;
      route_out.pull_up_pos <= up_pos & sense_pos_ff;
      route_out.pull_up_neg <= ~up_pos & sense_neg_ff;
      route_out.excite_pos  <= sense_pos_ff;
      route_out.excite_neg  <= sense_neg_ff;
      stat_out.pos_status   <= stat_pos_ff;
      stat_out.neg_status   <= stat_neg_ff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Bus request taken while idle
  sequence s_bus_request;
    (avs_read || avs_write) && !ack_ff;
  endsequence

  // Exactly one cycle of waitrequest low, then high again
  sequence s_one_wait_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence s_write_status;
    wr_go && lane0 && (idx == lod_pkg::IDX_STAT_POS);
  endsequence

  a_bus_answer: assert property (
    s_bus_request |=> s_one_wait_answer)
    else $error("bus answer not one cycle after request");

  a_status_read_only: assert property (
    (s_write_status and !comp_en) |=> stat_pos_ff == lod_pkg::RST_ZERO)
    else $error("status changed by write");

  a_status_capture: assert property (
    comp_en |=> stat_pos_ff == $past(comp_pos_off))
    else $error("positive status not captured");

  a_neg_capture: assert property (
    comp_en |=> stat_neg_ff == $past(comp_neg_off))
    else $error("negative status not captured");

  a_comp_off_clear: assert property (
    !comp_en |=> stat_neg_ff == lod_pkg::RST_ZERO)
    else $error("status set while comparators off");

  a_pin_dir_oe: assert property (
    1'b1 |=> port_pin_oe == ~$past(port_ff[lod_pkg::PORT_DIR_LSB +: 4]))
    else $error("pin enable does not follow direction");

  a_input_value_kept: assert property (
    wr_go && idx == lod_pkg::IDX_PORT && port_ff[lod_pkg::PORT_DIR_LSB] |=>
      port_ff[lod_pkg::PORT_VAL_LSB] ==
        $past(port_ff[lod_pkg::PORT_VAL_LSB]))
    else $error("input pin value changed by write");

  a_port_read_pins: assert property (
    rd_go && idx == lod_pkg::IDX_PORT |=>
      avs_readdata[lod_pkg::PORT_VAL_LSB +: 4] == $past(pins_ff))
    else $error("port read does not show pin levels");

  a_shared_ref_out: assert property (
    1'b1 |=> ctrl_out.shared_reference_switch ==
      $past(misc_one_ff[lod_pkg::SHREF_BIT]))
    else $error("reference switch output wrong");

  a_bias_route: assert property (
    sel_ff[0][2:0] == lod_pkg::SEL_BIAS_NEG |=> route_out.bias_to_neg[0])
    else $error("bias not routed to negative input");

  a_single_shot: assert property (
    1'b1 |=> ctrl_out.single_shot_mode ==
      $past(conversion_comparator_config_ff[lod_pkg::SINGLE_BIT]))
    else $error("conversion mode output wrong");

  a_threshold_out: assert property (
    1'b1 |=> ctrl_out.comparator_threshold ==
      $past(electrode_off_control_reg_ctrl_ff[lod_pkg::TH_LSB +: 3]))
    else $error("threshold output wrong");

  a_excite_enable: assert property (
    1'b1 |=> route_out.excite_pos == $past(sense_pos_ff))
    else $error("positive excitation enable wrong");

  a_pull_exclusive: assert property (
    (route_out.pull_up_pos & route_out.pull_up_neg) == lod_pkg::RST_ZERO)
    else $error("both inputs of a channel pulled up");

  a_dc_pull_dir: assert property (
    !is_ac |=> route_out.pull_up_pos ==
      (~$past(swap_ff) & $past(sense_pos_ff)))
    else $error("DC pull direction wrong");

  a_ac_alternate: assert property (
    is_ac |=> route_out.pull_up_pos ==
      (({8{$past(ac_phase)}} ^ $past(swap_ff)) & $past(sense_pos_ff)))
    else $error("AC pull direction does not follow phase");

endmodule // lod_regs

// ### shared/lod_pkg.sv
// Package for the electrode-off and port-pin register bank.
// Assumes a single 100 MHz clock domain and an Avalon-MM byte-addressed bus with four-byte words.
package lod_pkg;

  localparam int unsigned CHANNELS   = 8;
  localparam int unsigned PORT_PINS  = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SENSE_POS  = 8'h0F;
  localparam logic [7:0] IDX_SENSE_NEG  = 8'h10;
  localparam logic [7:0] IDX_DIR_SWAP   = 8'h11;
  localparam logic [7:0] IDX_STAT_POS   = 8'h12;
  localparam logic [7:0] IDX_STAT_NEG   = 8'h13;
  localparam logic [7:0] IDX_PORT       = 8'h14;
  localparam logic [7:0] IDX_MISC_ONE   = 8'h15;
  localparam logic [7:0] IDX_MISC_TWO   = 8'h16;
  localparam logic [7:0] IDX_CONVERSION_COMPARATOR_CONFIG    = 8'h17;
  localparam logic [7:0] IDX_ELECTRODE_OFF_CONTROL_REG_CTRL  = 8'h04;
  localparam logic [7:0] IDX_INPUT_SEL  = 8'h05;

  // Field positions
  localparam int unsigned PORT_VAL_LSB  = 4;
  localparam int unsigned PORT_DIR_LSB  = 0;
  localparam int unsigned SHREF_BIT     = 5;
  localparam int unsigned SINGLE_BIT    = 3;
  localparam int unsigned COMP_EN_BIT   = 1;
  localparam int unsigned CUR_LSB       = 2;
  localparam int unsigned FREQ_LSB      = 0;
  localparam int unsigned TH_LSB        = 5;
  localparam int unsigned SEL_CH_LSB    = 3;
  localparam int unsigned SEL_CODE_LSB  = 0;

  // Writable masks, reset values, select and frequency codes
  localparam logic [7:0] MASK_MISC_ONE  = 8'h20;
  localparam logic [7:0] MASK_MISC_TWO  = 8'h00;
  localparam logic [7:0] MASK_CONVERSION_COMPARATOR_CONFIG   = 8'h0A;
  localparam logic [7:0] RST_PORT       = 8'h0F;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [2:0] SEL_BIAS_POS   = 3'b110;
  localparam logic [2:0] SEL_BIAS_NEG   = 3'b111;
  localparam logic [1:0] FREQ_DC        = 2'b00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] pos_detect_enable;
    logic [7:0] neg_detect_enable;
    logic [7:0] excitation_direction_swap;
    logic [1:0] excitation_current_level;
    logic [2:0] comparator_threshold;
    logic [1:0] excitation_frequency_select;
    logic       shared_reference_switch;
    logic       single_shot_mode;
    logic       detect_comparator_enable;
  } lod_ctrl_t;

  typedef struct packed {
    logic [7:0] bias_to_pos;
    logic [7:0] bias_to_neg;
    logic [7:0] pull_up_pos;
    logic [7:0] pull_up_neg;
    logic [7:0] excite_pos;
    logic [7:0] excite_neg;
  } lod_route_t;

  typedef struct packed {
    logic [7:0] pos_status;
    logic [7:0] neg_status;
  } lod_stat_t;

endpackage

// ### testbench/lod_pin_model.sv
// Far-side model of the four port pins and the board that drives them.
// Assumes the bench drives ext_value on the pins that it marks in ext_en.
`timescale 1ns/100ps
module lod_pin_model (
  // Design side
  input  wire logic [3:0] port_pin_out,
  input  wire logic [3:0] port_pin_oe,
  // Board side
  input  wire logic [3:0] ext_value,
  input  wire logic [3:0] ext_en,
  // Resolved pin level
  output logic      [3:0] port_pin_in
);
  // Pins left undriven read high through the board pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      port_pin_in[i] = port_pin_oe[i] ? port_pin_out[i]
                     : (ext_en[i] ? ext_value[i] : 1'b1);
    end
  end
endmodule // lod_pin_model

// ### testbench/tb_top.sv
// Self-checking bench for the electrode-off and port-pin register bank.
// Assumes the design answers Avalon-MM requests and resets synchronously.
`timescale 1ns/100ps
module tb_top;
  logic                ref_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic [7:0]          avs_address = 8'h00;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = 32'h0000_0000;
  logic [3:0]          avs_byteenable = 4'hF;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [1:0]          avs_response;
  logic [7:0]          comp_pos_off = 8'h00;
  logic [7:0]          comp_neg_off = 8'h00;
  logic                ac_phase = 1'b0;
  logic [3:0]          port_pin_in, port_pin_out, port_pin_oe;
  logic [3:0]          ext_value = 4'h0;
  logic [3:0]          ext_en = 4'hF;
  lod_pkg::lod_ctrl_t  ctrl_out;
  lod_pkg::lod_route_t route_out;
  lod_pkg::lod_stat_t  stat_out;
  int                  miscompares = 0;
  int                  checked = 0;
  int                  seed = 14583;
  logic [7:0] tbl [8] = '{lod_pkg::IDX_SENSE_POS, lod_pkg::IDX_SENSE_NEG,
    lod_pkg::IDX_DIR_SWAP, lod_pkg::IDX_STAT_POS, lod_pkg::IDX_STAT_NEG,
    lod_pkg::IDX_MISC_ONE, lod_pkg::IDX_MISC_TWO, lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG};

  lod_regs uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .comp_pos_off(comp_pos_off),
    .comp_neg_off(comp_neg_off), .ac_phase(ac_phase),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .ctrl_out(ctrl_out), .route_out(route_out),
    .stat_out(stat_out));
  lod_pin_model u_pins (.port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .ext_value(ext_value), .ext_en(ext_en),
    .port_pin_in(port_pin_in));

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ac_phase <= ~ac_phase;

  // ---------------------------------------------------------------
  // Expectation helpers and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] wr_mask(input logic [7:0] idx);
    case (idx)
      lod_pkg::IDX_MISC_ONE: wr_mask = lod_pkg::MASK_MISC_ONE;
      lod_pkg::IDX_MISC_TWO: wr_mask = lod_pkg::MASK_MISC_TWO;
      lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG:  wr_mask = lod_pkg::MASK_CONVERSION_COMPARATOR_CONFIG;
      lod_pkg::IDX_STAT_POS: wr_mask = 8'h00;
      lod_pkg::IDX_STAT_NEG: wr_mask = 8'h00;
      default:               wr_mask = 8'hFF;
    endcase
  endfunction

  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address    <= {idx[5:0], 2'b00};
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {24'h00_0000, wd};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, 4'hF, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, 4'hF, d);
    chk(nm, {24'h00_0000, e}, d);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  v, sp, sn, cp, cn, pa;
    logic [7:0]  last [8];
    logic [3:0]  m, d4, e4, x4, pval;
    logic [31:0] d;
    ext_value <= 4'($random(seed));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("oe_rst", 32'h0, {28'h000_0000, port_pin_oe});
    rchk("port_rst", lod_pkg::IDX_PORT, {ext_value, 4'hF});
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 8; k++) begin
        rchk("reg_rst", tbl[k], r == 0 ? 8'h00 : last[k]);
        v = (r == 2) ? 8'hFF : 8'($random(seed));
        last[k] = v & wr_mask(tbl[k]);
        wreg(tbl[k], k > 4 ? last[k] : v);
        rchk("reg_rw", tbl[k], last[k]);
      end
    end
    sp = 8'($random(seed));
    sn = 8'($random(seed));
    cp = 8'($random(seed));
    cn = 8'($random(seed));
    wreg(lod_pkg::IDX_SENSE_POS, sp);
    wreg(lod_pkg::IDX_SENSE_NEG, sn);
    wreg(lod_pkg::IDX_DIR_SWAP, cp);
    wreg(lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG, 8'h02);
    comp_pos_off <= cp;
    comp_neg_off <= cn;
    repeat (3) @(posedge ref_clk);
    chk("sense_p", sp, ctrl_out.pos_detect_enable);
    chk("sense_n", sn, ctrl_out.neg_detect_enable);
    chk("swap", cp, ctrl_out.excitation_direction_swap);
    chk("comp_en", 1, ctrl_out.detect_comparator_enable);
    chk("single", 0, ctrl_out.single_shot_mode);
    chk("shref", 1, ctrl_out.shared_reference_switch);
    bus(1'b0, lod_pkg::IDX_STAT_POS, 8'h00, 4'hF, d);
    chk("stat_p", cp & sp, d[7:0] & sp);
    wreg(lod_pkg::IDX_STAT_NEG, ~cn);
    rchk("stat_n", lod_pkg::IDX_STAT_NEG, cn);
    chk("stat_out", {cp, cn}, stat_out);
    wreg(lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG, 8'h08);
    repeat (3) @(posedge ref_clk);
    chk("single", 1, ctrl_out.single_shot_mode);
    rchk("stat_off", lod_pkg::IDX_STAT_POS, 8'h00);
    bus(1'b1, lod_pkg::IDX_DIR_SWAP, ~cp, 4'hE, d);
    rchk("no_lane", lod_pkg::IDX_DIR_SWAP, cp);
    rchk("unmapped", 8'h30, 8'h00);
    chk("resp", 32'h0, {30'h0000_0000, avs_response});
    for (int f = 0; f < 4; f++) begin
      v = {3'($random(seed)), 1'b0, 2'($random(seed)), 2'(f)};
      wreg(lod_pkg::IDX_ELECTRODE_OFF_CONTROL_REG_CTRL, v);
      repeat (3) @(posedge ref_clk);
      chk("thresh", v[7:5], ctrl_out.comparator_threshold);
      chk("current", v[3:2], ctrl_out.excitation_current_level);
      chk("freq", v[1:0], ctrl_out.excitation_frequency_select);
      if (f == 0) begin
        chk("pull_p", ~cp & sp, route_out.pull_up_pos);
        chk("pull_n", cp & sn, route_out.pull_up_neg);
        chk("excite", {sp, sn}, {route_out.excite_pos,
                                 route_out.excite_neg});
      end else begin
        pa = route_out.pull_up_pos;
        @(posedge ref_clk);
        chk("ac_flip", sp, pa ^ route_out.pull_up_pos);
      end
    end
    for (int ch = 0; ch < 8; ch++) begin
      wreg(lod_pkg::IDX_INPUT_SEL, {2'b00, 3'(ch), lod_pkg::SEL_BIAS_POS});
      repeat (3) @(posedge ref_clk);
      chk("bias_p", 1, route_out.bias_to_pos[ch]);
      wreg(lod_pkg::IDX_INPUT_SEL, {2'b00, 3'(ch), lod_pkg::SEL_BIAS_NEG});
      repeat (3) @(posedge ref_clk);
      chk("bias_n", 2'b10, {route_out.bias_to_neg[ch],
                            route_out.bias_to_pos[ch]});
    end
    pval = lod_pkg::RST_PORT[7:4];
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
      e4 = 4'($random(seed));
      x4 = (i == 2) ? 4'h0 : 4'($random(seed));
      ext_value <= e4;
      ext_en    <= m & x4;
      wreg(lod_pkg::IDX_PORT, {pval, m});
      d4 = 4'($random(seed));
      wreg(lod_pkg::IDX_PORT, {d4, m});
      pval = (d4 & ~m) | (pval & m);
      repeat (3) @(posedge ref_clk);
      chk("oe", {28'h000_0000, ~m}, port_pin_oe);
      chk("out", {28'h000_0000, pval}, port_pin_out);
      rchk("port", lod_pkg::IDX_PORT,
           {(pval & ~m) | (m & ((e4 & x4) | ~x4)), m});
    end
    // Second reset in mid-run
    ext_en  <= 4'hF;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("oe_rst2", 32'h0, {28'h000_0000, port_pin_oe});
    rchk("cfg_rst2", lod_pkg::IDX_CONVERSION_COMPARATOR_CONFIG, 8'h00);
    rchk("port_rst2", lod_pkg::IDX_PORT, {ext_value, 4'hF});
    tally_and_finish();
  end
endmodule // tb_top
